// File: core/msqd_pkg.sv
// shared constants and types for the microprogram sequencer
package msqd_pkg;

  // microprogram address and store size
  localparam int ADDR_W = 6;
  localparam int MEM_WORDS = 64;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 6'h3F;
  localparam logic [ADDR_W-1:0] COUNT_RESET = 6'h00;

  // microword layout, low bit first
  localparam int DATA_LSB = 0;
  localparam int OP_LSB = 6;
  localparam int OP_W = 5;
  localparam int SEL_LSB = 11;
  localparam int SEL_W = 3;
  localparam int POL_BIT = 14;
  localparam int CTRL_LSB = 15;
  localparam int CTRL_W = 16;
  localparam int WORD_W = 31;

  // test inputs: six pins plus the condition code pin
  localparam int TEST_W = 6;
  localparam int PIN_W = 7;

  // return stack
  localparam int STACK_DEPTH = 9;
  localparam int STACK_PTR_W = 4;

  // register port map, byte addresses
  localparam int BUS_AW = 9;
  localparam logic [BUS_AW-1:0] REG_STATUS = 9'h100;
  localparam logic [BUS_AW-1:0] REG_COUNT = 9'h104;
  localparam logic [BUS_AW-1:0] REG_WORD = 9'h108;
  localparam int STATUS_MATCH_BIT = 7;
  localparam int STATUS_DEPTH_LSB = 8;

  // five-bit operation codes
  typedef enum logic [OP_W-1:0] {
    OP_RETURN_LOAD_IMM = 5'h00,
    OP_RETURN_NESTED_LOAD_IMM = 5'h01,
    OP_RETURN = 5'h02,
    OP_RETURN_NESTED = 5'h03,
    OP_LOAD_IMM = 5'h04,
    OP_LOAD_IMM_NESTED = 5'h05,
    OP_LOAD_TEST = 5'h06,
    OP_LOAD_TEST_NESTED = 5'h07,
    OP_COUNTED_LOOP = 5'h08,
    OP_COUNT_DOWN = 5'h09,
    OP_COUNTED_LOOP_NESTED = 5'h0A,
    OP_JUMP_COUNT_ZERO = 5'h0B,
    OP_WAIT_LOAD_IMM = 5'h0C,
    OP_SEQUENTIAL = 5'h0D,
    OP_WAIT_LOAD_TEST = 5'h0E,
    OP_JUMP_TEST = 5'h0F,
    OP_COMPARE0 = 5'h10,
    OP_COMPARE1 = 5'h11,
    OP_COMPARE2 = 5'h12,
    OP_COMPARE3 = 5'h13,
    OP_PUSH_LOAD_IMM = 5'h14,
    OP_PUSH = 5'h15,
    OP_PUSH_LOAD_TEST = 5'h16,
    OP_PUSH_NESTED = 5'h17,
    OP_FORK = 5'h18,
    OP_JUMP_IMM = 5'h19,
    OP_WAIT_BRANCH = 5'h1A,
    OP_BRANCH_COUNT_WAIT = 5'h1B,
    OP_CALL_IMM = 5'h1C,
    OP_CALL_IMM_NESTED = 5'h1D,
    OP_CALL_TEST = 5'h1E,
    OP_CALL_TEST_NESTED = 5'h1F
  } msqd_op_t;

endpackage : msqd_pkg

// File: core/msqd_stack.sv
`timescale 1ns/1ps
// return stack, up to two pushes or two pops per cycle
module msqd_stack
  import msqd_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int W = ADDR_W
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [1:0] push_n_i,
  input wire logic [W-1:0] push_a_i,
  input wire logic [W-1:0] push_b_i,
  input wire logic [1:0] pop_n_i,
  output logic [W-1:0] top_o,
  output logic [W-1:0] second_o,
  output logic [STACK_PTR_W-1:0] depth_o
);

  // pointer must address every entry
  if (DEPTH < 2 || DEPTH >= (1 << STACK_PTR_W))
  begin : g_depth_check
    $error("msqd_stack: DEPTH out of range");
  end

  logic [W-1:0] mem [DEPTH];
  logic [STACK_PTR_W-1:0] sp;
  logic fits;

  // a push that would overflow is dropped whole
  assign fits = (int'(sp) + int'(push_n_i)) <= DEPTH;

  // stack pointer
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      sp <= '0;
    else if (push_n_i != 2'd0)
    begin
      if (fits)
        sp <= sp + STACK_PTR_W'(push_n_i);
    end
    else if (pop_n_i != 2'd0)
      sp <= (sp >= STACK_PTR_W'(pop_n_i)) ? sp - STACK_PTR_W'(pop_n_i) : '0;
  end

  // entry storage, b lands above a
  always_ff @(posedge clk_i)
  begin
    if (!reset_i && push_n_i != 2'd0 && fits)
    begin
      mem[sp] <= push_a_i;
      if (push_n_i == 2'd2)
        mem[sp + 1'b1] <= push_b_i;
    end
  end

  // empty entries read as zero
  assign top_o = (sp >= 4'h1) ? mem[sp - 4'h1] : '0;
  assign second_o = (sp >= 4'h2) ? mem[sp - 4'h2] : '0;
  assign depth_o = sp;

endmodule : msqd_stack

// File: core/msqd_sequencer.sv
`timescale 1ns/1ps
module msqd_sequencer
  import msqd_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [TEST_W-1:0] test_i,
  input wire logic cond_code_i,
  input wire logic [BUS_AW-1:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic bus_we_i,
  input wire logic bus_re_i,
  output logic [31:0] bus_rdata_o,
  output logic [CTRL_W-1:0] ctrl_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [ADDR_W-1:0] count_o,
  output logic match_o
);

  // store size must fit the address width
  if (MEM_WORDS != (1 << ADDR_W))
  begin : g_size_check
    $error("msqd_sequencer: store size and address width disagree");
  end

  // next sequential address, wraps from 63 to 0
  function automatic logic [ADDR_W-1:0] msqd_seq(input logic [ADDR_W-1:0] a);
    return a + 1'b1;
  endfunction : msqd_seq

  // condition source select and polarity
  function automatic logic msqd_cond(input logic [SEL_W-1:0] sel, input logic pol,
                                     input logic [PIN_W-1:0] pins, input logic m);
    logic [7:0] src;
    src = {m, pins};
    return src[sel] == pol;
  endfunction : msqd_cond

  logic [WORD_W-1:0] mem [MEM_WORDS];
  logic [WORD_W-1:0] pipe;
  logic [ADDR_W-1:0] pc;
  logic [ADDR_W-1:0] count;
  logic match;
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] pins_q;
  logic [ADDR_W-1:0] data;
  logic [ADDR_W-1:0] test_value;
  logic [ADDR_W-1:0] seq;
  logic [SEL_W-1:0] sel;
  logic pol;
  logic cond;
  msqd_op_t op;
  logic [ADDR_W-1:0] next_addr;
  logic [ADDR_W-1:0] next_count;
  logic next_match;
  logic [1:0] push_n;
  logic [ADDR_W-1:0] push_a;
  logic [ADDR_W-1:0] push_b;
  logic [1:0] pop_n;
  logic [ADDR_W-1:0] stack_top;
  logic [ADDR_W-1:0] stack_second;
  logic [STACK_PTR_W-1:0] stack_depth;
  logic mem_sel;
  logic [ADDR_W-1:0] mem_idx;

  // pin synchroniser, three stages; runs through reset so pins are settled when it ends
  always_ff @(posedge clk_i)
  begin
    sync1 <= {cond_code_i, test_i};
    sync2 <= sync1;
    sync3 <= sync2;
  end

  // a pin change counts once stages two and three agree
  always_ff @(posedge clk_i)
    pins_q <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & pins_q);

  // microword fields
  assign data = pipe[DATA_LSB +: ADDR_W];
  assign op = msqd_op_t'(pipe[OP_LSB +: OP_W]);
  assign sel = pipe[SEL_LSB +: SEL_W];
  assign pol = pipe[POL_BIT];
  assign test_value = pins_q[TEST_W-1:0];
  assign seq = msqd_seq(pc);
  assign cond = msqd_cond(sel, pol, pins_q, match);

  // next address, stack and counter actions
  always_comb
  begin
    next_addr = seq;
    next_count = count;
    next_match = match;
    push_n = 2'd0;
    push_a = seq;
    push_b = seq;
    pop_n = 2'd0;
    unique case (op)
      OP_JUMP_IMM:
        if (cond)
          next_addr = data;
      OP_JUMP_TEST:
        if (cond)
          next_addr = test_value;
      OP_JUMP_COUNT_ZERO:
        if (count == COUNT_RESET)
          next_addr = data;
      OP_FORK:
        next_addr = cond ? data : stack_top;
      OP_CALL_IMM, OP_CALL_IMM_NESTED, OP_CALL_TEST, OP_CALL_TEST_NESTED:
        if (cond)
        begin
          next_addr = op[1] ? test_value : data;
          push_n = op[0] ? 2'd2 : 2'd1;
          push_a = op[0] ? count : seq;
        end
      OP_LOAD_IMM, OP_LOAD_IMM_NESTED, OP_LOAD_TEST, OP_LOAD_TEST_NESTED:
        if (cond)
        begin
          next_count = op[1] ? test_value : data;
          push_n = op[0] ? 2'd1 : 2'd0;
          push_a = count;
        end
      OP_PUSH, OP_PUSH_LOAD_IMM, OP_PUSH_LOAD_TEST:
        if (cond)
        begin
          push_n = 2'd1;
          if (op == OP_PUSH_LOAD_IMM)
            next_count = data;
          else if (op == OP_PUSH_LOAD_TEST)
            next_count = test_value;
        end
      OP_PUSH_NESTED:
        if (cond)
        begin
          push_n = 2'd2;
          push_a = count;
        end
      OP_RETURN, OP_RETURN_NESTED, OP_RETURN_LOAD_IMM, OP_RETURN_NESTED_LOAD_IMM:
        if (cond)
        begin
          next_addr = stack_top;
          pop_n = op[0] ? 2'd2 : 2'd1;
          if (op == OP_RETURN_NESTED)
            next_count = stack_second;
          else if (!op[1])
            next_count = data;
        end
      OP_COUNT_DOWN:
        if (cond)
          next_count = count - 1'b1;
      OP_WAIT_LOAD_IMM, OP_WAIT_LOAD_TEST:
        if (count != COUNT_RESET)
        begin
          next_addr = pc;
          next_count = count - 1'b1;
        end
        else
          next_count = op[1] ? test_value : data;
      OP_BRANCH_COUNT_WAIT:
        if (cond)
          next_addr = data;
        else if (count != COUNT_RESET)
        begin
          next_addr = pc;
          next_count = count - 1'b1;
        end
      OP_WAIT_BRANCH:
        next_addr = cond ? data : pc;
      OP_COUNTED_LOOP, OP_COUNTED_LOOP_NESTED:
        if (count != COUNT_RESET)
        begin
          next_addr = data;
          next_count = count - 1'b1;
        end
        else if (op[1])
        begin
          pop_n = 2'd1;
          next_count = stack_top;
        end
      OP_SEQUENTIAL:
        next_addr = seq;
      OP_COMPARE0, OP_COMPARE1, OP_COMPARE2, OP_COMPARE3:
        next_match = (test_value == data);
    endcase
  end

  // return stack
  msqd_stack #(
    .DEPTH(DEPTH),
    .W(ADDR_W)
  ) u_stack (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .push_n_i(reset_i ? 2'd0 : push_n),
    .push_a_i(push_a),
    .push_b_i(push_b),
    .pop_n_i(reset_i ? 2'd0 : pop_n),
    .top_o(stack_top),
    .second_o(stack_second),
    .depth_o(stack_depth)
  );

  // address counter and pipeline fetch
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pc <= RESET_ADDR;
      pipe <= mem[RESET_ADDR];
    end
    else
    begin
      pc <= next_addr;
      pipe <= mem[next_addr];
    end
  end

  // loop counter
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      count <= COUNT_RESET;
    else
      count <= next_count;
  end

  // compare match flag
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      match <= 1'b0;
    else
      match <= next_match;
  end

  // register port decode
  assign mem_sel = (bus_addr_i[BUS_AW-1] == 1'b0);
  assign mem_idx = bus_addr_i[2 +: ADDR_W];

  // microprogram store, written over the register port
  always_ff @(posedge clk_i)
  begin
    if (bus_we_i && mem_sel)
      mem[mem_idx] <= bus_wdata_i[WORD_W-1:0];
  end

  // read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !bus_re_i)
      bus_rdata_o <= '0;
    else if (mem_sel)
      bus_rdata_o <= {1'b0, mem[mem_idx]};
    else if (bus_addr_i == REG_STATUS)
      bus_rdata_o <= {20'h00000, stack_depth, match, 1'b0, pc};
    else if (bus_addr_i == REG_COUNT)
      bus_rdata_o <= {26'h0000000, count};
    else if (bus_addr_i == REG_WORD)
      bus_rdata_o <= {1'b0, pipe};
    else
      bus_rdata_o <= '0;
  end

  // outputs straight from registers
  assign ctrl_o = pipe[CTRL_LSB +: CTRL_W];
  assign addr_o = pc;
  assign count_o = count;
  assign match_o = match;

  // reset lands on the top word with the flag clear
  reset_top_a: assert property (@(posedge clk_i) reset_i |=> (pc == RESET_ADDR && !match))
    else $error("reset did not load top address");

  // immediate jump
  jump_immediate_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (op == OP_JUMP_IMM) |=> (pc == ($past(cond) ? $past(data) : $past(seq))))
    else $error("jump immediate took wrong address");

  // jump to test address
  jump_test_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (op == OP_JUMP_TEST && cond) |=> (pc == $past(test_value)))
    else $error("jump to test address missed");

  // jump on zero count ignores the condition
  zero_jump_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (op == OP_JUMP_COUNT_ZERO && count != COUNT_RESET) |=> (pc == $past(seq)))
    else $error("jump on count zero taken with nonzero count");

  // fork falls back to the stack top
  fork_stack_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (op == OP_FORK && !cond) |=> (pc == $past(stack_top)))
    else $error("fork did not take stack top");

  // call saves the return address
  call_push_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (op == OP_CALL_IMM && cond && stack_depth < 4'h8) |=>
    (stack_top == $past(seq) && pc == $past(data)))
    else $error("call did not save return address");

  // count down on condition
  count_down_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (op == OP_COUNT_DOWN) |=> (count == ($past(cond) ? $past(count) - 1'b1 : $past(count))))
    else $error("count down wrong");

  // wait holds the word while counting
  wait_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (op == OP_WAIT_LOAD_IMM && count == 6'h02 && $stable(pipe)) |=>
    (pc == $past(pc)) ##1 (pc == $past(pc, 2) && count == COUNT_RESET))
    else $error("wait did not hold");

  // repeat until condition
  wait_branch_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (op == OP_WAIT_BRANCH && !cond) |=> (pc == $past(pc)))
    else $error("wait branch did not repeat");

  // counted loop returns to the data address
  loop_back_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (op == OP_COUNTED_LOOP && count != COUNT_RESET) |=>
    (pc == $past(data) && count == $past(count) - 1'b1))
    else $error("counted loop wrong");

  // plain advance
  sequential_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (op == OP_SEQUENTIAL) |=> (pc == $past(pc) + 1'b1 && $stable(count)))
    else $error("advance wrong");

  // compare sets the match flag
  compare_flag_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (op inside {OP_COMPARE0, OP_COMPARE1, OP_COMPARE2, OP_COMPARE3}) |=>
    (match == ($past(test_value) == $past(data))))
    else $error("compare flag wrong");

  // false condition on a load leaves stack and counter alone
  false_cond_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (op == OP_LOAD_IMM && !cond) |=> ($stable(count) && $stable(stack_depth)))
    else $error("false condition changed state");

endmodule : msqd_sequencer

// File: testbench/msqd_partner.sv
`timescale 1ns/1ps
// surrounding logic: drives test pins and condition code, watches the control field
module msqd_partner
  import msqd_pkg::*;
(
  input wire logic clk_i,
  input wire logic load_i,
  input wire logic [TEST_W-1:0] pins_i,
  input wire logic cc_i,
  input wire logic [CTRL_W-1:0] ctrl_i,
  output logic [TEST_W-1:0] test_o,
  output logic cond_code_o,
  output logic [CTRL_W-1:0] last_ctrl_o
);
  // known pin levels from time zero
  initial
  begin
    test_o = 6'h00;
    cond_code_o = 1'b0;
    last_ctrl_o = 16'h0000;
  end

  // pins move only just after an edge, then stay put
  always @(posedge clk_i)
  begin
    if (load_i)
    begin
      test_o <= pins_i;
      cond_code_o <= cc_i;
    end
    last_ctrl_o <= ctrl_i;
  end
endmodule : msqd_partner

// File: testbench/testbench.sv
`timescale 1ns/1ps
// random microprograms run against a reference sequencer kept in the bench
module testbench
  import msqd_pkg::*;
;
  localparam int RUNS = 300;
  localparam int STEPS = 6;
  localparam int LIMIT = 40000;
  localparam int STACK_MAX = 15;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [BUS_AW-1:0] bus_addr_i = 9'h000;
  logic [31:0] bus_wdata_i = 32'h00000000;
  logic bus_we_i = 1'b0;
  logic bus_re_i = 1'b0;
  logic pin_load = 1'b0;
  logic [TEST_W-1:0] pin_val = 6'h00;
  logic cc_val = 1'b0;
  logic [TEST_W-1:0] test_i;
  logic cond_code_i;
  logic [31:0] bus_rdata_o;
  logic [CTRL_W-1:0] ctrl_o;
  logic [ADDR_W-1:0] addr_o;
  logic [ADDR_W-1:0] count_o;
  logic match_o;
  // reference state
  logic [30:0] mem [MEM_WORDS];
  logic [5:0] pc, cnt, tv;
  logic mt, ccv;
  logic [5:0] stk [$];
  logic [31:0] exp_rd, rnd;
  integer seed = 9;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  msqd_partner far_end (.clk_i(clk_i), .load_i(pin_load), .pins_i(pin_val), .cc_i(cc_val),
    .ctrl_i(ctrl_o), .test_o(test_i), .cond_code_o(cond_code_i), .last_ctrl_o());

  msqd_sequencer #(.DEPTH(STACK_MAX)) uut (.clk_i(clk_i), .reset_i(reset_i), .test_i(test_i),
    .cond_code_i(cond_code_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
    .bus_we_i(bus_we_i), .bus_re_i(bus_re_i), .bus_rdata_o(bus_rdata_o), .ctrl_o(ctrl_o),
    .addr_o(addr_o), .count_o(count_o), .match_o(match_o));

  always #20 clk_i = ~clk_i;

  // hang guard
  always @(posedge clk_i)
  begin
    cycles = cycles + 1;
    if (cycles == LIMIT)
    begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // empty stack yields address zero
  function automatic logic [5:0] pop();
    if (stk.size() == 0)
      return 6'h00;
    return stk.pop_front();
  endfunction : pop

  // read address mix: status, count, word, unmapped, store
  function automatic logic [8:0] pick(input logic [31:0] r);
    case (r[10:8])
      3'h0: return REG_STATUS;
      3'h1: return REG_COUNT;
      3'h2: return REG_WORD;
      3'h3: return 9'h10C;
      default: return {1'b0, r[5:0], 2'b00};
    endcase
  endfunction : pick

  function automatic logic [31:0] mread(input logic [8:0] a);
    if (a < REG_STATUS)
      return {1'b0, mem[a[7:2]]};
    if (a == REG_STATUS)
      return {20'h00000, 4'(stk.size()), mt, 1'b0, pc};
    if (a == REG_COUNT)
      return {26'h0000000, cnt};
    if (a == REG_WORD)
      return {1'b0, mem[pc]};
    return 32'h00000000;
  endfunction : mread

  // one instruction of the reference sequencer
  task automatic step();
    logic [30:0] w;
    logic [5:0] d, nx, t;
    logic [4:0] op;
    logic [2:0] sel;
    logic src, c;
    w = mem[pc];
    d = w[5:0];
    op = w[10:6];
    sel = w[13:11];
    src = (sel < 3'h6) ? tv[sel] : ((sel == 3'h6) ? ccv : mt);
    c = (src == w[14]);
    nx = pc + 6'h01;
    case (op)
      5'h19: if (c) nx = d;
      5'h0F: if (c) nx = tv;
      5'h0B: if (cnt == 6'h00) nx = d;
      5'h18: nx = c ? d : ((stk.size() > 0) ? stk[0] : 6'h00);
      5'h1C, 5'h1D, 5'h1E, 5'h1F:
        if (c)
        begin
          if (op[0]) stk.push_front(cnt);
          stk.push_front(nx);
          nx = op[1] ? tv : d;
        end
      5'h04, 5'h05, 5'h06, 5'h07:
        if (c)
        begin
          if (op[0]) stk.push_front(cnt);
          cnt = op[1] ? tv : d;
        end
      5'h14, 5'h15, 5'h16, 5'h17:
        if (c)
        begin
          if (op == 5'h17) stk.push_front(cnt);
          stk.push_front(nx);
          if (op == 5'h14) cnt = d;
          if (op == 5'h16) cnt = tv;
        end
      5'h00, 5'h01, 5'h02, 5'h03:
        if (c)
        begin
          nx = pop();
          t = op[0] ? pop() : cnt;
          cnt = op[1] ? t : d;
        end
      5'h09: if (c) cnt = cnt - 6'h01;
      5'h0C, 5'h0E:
        if (cnt != 6'h00)
        begin
          nx = pc;
          cnt = cnt - 6'h01;
        end
        else
          cnt = op[1] ? tv : d;
      5'h1B:
        if (c)
          nx = d;
        else if (cnt != 6'h00)
        begin
          nx = pc;
          cnt = cnt - 6'h01;
        end
      5'h1A: nx = c ? d : pc;
      5'h08, 5'h0A:
        if (cnt != 6'h00)
        begin
          nx = d;
          cnt = cnt - 6'h01;
        end
        else if (op[1])
          cnt = pop();
      5'h10, 5'h11, 5'h12, 5'h13: mt = (tv == d);
      default: ;
    endcase
    pc = nx;
  endtask : step

  initial
  begin
    for (int r = 0; r < RUNS; r++)
    begin
      // new pins and a fresh random store, all under reset
      @(posedge clk_i);
      reset_i <= 1'b1;
      bus_re_i <= 1'b0;
      rnd = $random(seed);
      pin_val <= rnd[5:0];
      cc_val <= rnd[6];
      pin_load <= 1'b1;
      tv = rnd[5:0];
      ccv = rnd[6];
      for (int i = 0; i < MEM_WORDS; i++)
      begin
        @(posedge clk_i);
        pin_load <= 1'b0;
        rnd = $random(seed);
        bus_we_i <= 1'b1;
        bus_addr_i <= 9'(4 * i);
        bus_wdata_i <= rnd;
        mem[i] = rnd[30:0];
      end
      @(posedge clk_i);
      bus_we_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      chk(addr_o, 6'h3F);
      chk(count_o, 6'h00);
      chk(match_o, 1'b0);
      chk(ctrl_o, mem[63][30:15]);
      @(posedge clk_i);
      reset_i <= 1'b0;
      pc = 6'h3F;
      cnt = 6'h00;
      mt = 1'b0;
      stk.delete();
      exp_rd = 32'h00000000;
      // free run with a register read at every edge
      for (int k = 0; k < STEPS; k++)
      begin
        @(posedge clk_i);
        step();
        rnd = $random(seed);
        bus_addr_i <= pick(rnd);
        bus_re_i <= 1'b1;
        #1;
        chk(addr_o, pc);
        chk(count_o, cnt);
        chk(match_o, mt);
        chk(ctrl_o, mem[pc][30:15]);
        chk(bus_rdata_o, exp_rd);
        exp_rd = mread(pick(rnd));
      end
      @(posedge clk_i);
      bus_re_i <= 1'b0;
      reset_i <= 1'b1;
      #1;
      chk(bus_rdata_o, exp_rd);
    end
    stop_test();
  end
endmodule : testbench
